//--- rtl/sfpi_pkg.sv
// Constants and types for the serial flash pin interface
package sfpi_pkg;
  localparam int unsigned sfpi_clock_mhz = 25;
  localparam logic [2:0] sfpi_bit_count_reset = 3'h0;
  localparam logic [2:0] sfpi_last_bit = 3'h7;
  localparam logic [7:0] sfpi_byte_reset = 8'h00;
  localparam int unsigned sfpi_sector_count = 8;
  localparam int unsigned sfpi_sector_width = 3;
  localparam logic [7:0] sfpi_prot_reset = 8'h00;
  typedef enum logic [1:0] {
    sfpi_idle = 2'b00,
    sfpi_active = 2'b01,
    sfpi_busy = 2'b10,
    sfpi_reset = 2'b11
  } sfpi_state_e;
  typedef enum logic [2:0] {
    sfpi_op_none = 3'b000,
    sfpi_op_program = 3'b001,
    sfpi_op_erase = 3'b010,
    sfpi_op_prot_write = 3'b011,
    sfpi_op_prot_arm = 3'b100,
    sfpi_op_lockdown = 3'b101
  } sfpi_op_e;
endpackage

//--- rtl/sfpi_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module sfpi_sync #(
  parameter int unsigned width = 1,
  parameter logic [width-1:0] init = '0
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [width-1:0] din,
  output logic [width-1:0] dout
);
  logic [width-1:0] stage1;
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      stage1 <= init;
      dout <= init;
    end
    else
    begin
      stage1 <= din;
      dout <= stage1;
    end
  end
endmodule

//--- rtl/sfpi_core.sv
// Serial flash pin interface: framing, shifting, write-protect gating
`timescale 1ns/1ps
// Contract
// - Chip select fall starts a command
// - Chip select rise ends command framing
// - Busy cycle delays standby until done
// - Input bits captured on clock rise
// - Output bits shifted on clock fall
// - Deselected input activity is ignored
// - Deselected output stays high impedance
// - Write-protect low blocks flagged sectors
// - Hardware and software protection independent
// - Write-protect low freezes protection register
// - Arm and lockdown still accepted
// - Reset low aborts and holds the reset state
module sfpi_core
(
  input wire logic clock,
  input wire logic srst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  input wire logic reset_n,
  output logic so_out,
  output logic so_oe_n,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic frame_start,
  output logic frame_end,
  input wire logic [7:0] tx_byte,
  output logic tx_load,
  input wire logic [2:0] op_kind,
  input wire logic [2:0] op_sector,
  input wire logic [7:0] op_prot_data,
  input wire logic op_valid,
  input wire logic soft_prot_armed,
  input wire logic busy_done,
  output logic op_accept,
  output logic op_reject,
  output logic [7:0] prot_reg,
  output logic standby,
  output logic busy
);
  import sfpi_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [4:0] pins_sync;
  sfpi_sync #(.width(5), .init(5'h13)) u_sync (
    .clock(clock),
    .srst(srst),
    .din({cs_n, sck, si, wp_n, reset_n}),
    .dout(pins_sync)
  );
  wire cs_n_s = pins_sync[4];
  wire sck_s = pins_sync[3];
  wire si_s = pins_sync[2];
  wire wp_n_s = pins_sync[1];
  wire reset_n_s = pins_sync[0];

  logic cs_n_d;
  logic sck_d;
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      cs_n_d <= 1'b1;
      sck_d <= 1'b0;
    end
    else
    begin
      cs_n_d <= cs_n_s;
      sck_d <= sck_s;
    end
  end

  // ****************************************
  // Edge decode
  // ****************************************
  wire hold_reset = srst | ~reset_n_s;
  wire cs_fall = cs_n_d & ~cs_n_s & reset_n_s;
  wire cs_rise = ~cs_n_d & cs_n_s;
  wire selected = ~cs_n_s & ~cs_n_d;
  wire sck_rise = ~sck_d & sck_s & selected;
  wire sck_fall = sck_d & ~sck_s & selected;

  // ****************************************
  // Framing state
  // ****************************************
  sfpi_state_e state;
  sfpi_state_e next_state;
  logic busy_pending;
  always_comb
  begin
    next_state = state;
    unique case (state)
      sfpi_reset: next_state = sfpi_idle;
      sfpi_idle: if (cs_fall) next_state = sfpi_active;
      sfpi_active:
        if (cs_rise) next_state = busy_pending ? sfpi_busy : sfpi_idle;
      sfpi_busy:
        if (busy_done) next_state = sfpi_idle;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (hold_reset)
      state <= sfpi_reset;
    else
      state <= next_state;
  end
  assign standby = (state == sfpi_idle) | (state == sfpi_reset);
  assign busy = (state == sfpi_busy);
  assign frame_start = cs_fall & (state == sfpi_idle);
  assign frame_end = cs_rise & (state == sfpi_active);

  // ****************************************
  // Receive shifter
  // ****************************************
  logic [2:0] bit_count;
  logic [7:0] rx_shift;
  wire [7:0] next_rx_shift = {rx_shift[6:0], si_s};
  wire byte_done = sck_rise & (bit_count == sfpi_last_bit) & (state == sfpi_active);
  always_ff @(posedge clock)
  begin
    if (hold_reset | cs_fall | cs_rise)
    begin
      bit_count <= sfpi_bit_count_reset;
      rx_shift <= sfpi_byte_reset;
    end
    else if (sck_rise && state == sfpi_active)
    begin
      bit_count <= bit_count + 3'h1;
      rx_shift <= next_rx_shift;
    end
  end
  always_ff @(posedge clock)
  begin
    if (hold_reset)
    begin
      rx_byte <= sfpi_byte_reset;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= byte_done;
      if (byte_done)
        rx_byte <= next_rx_shift;
    end
  end

  // ****************************************
  // Transmit shifter
  // ****************************************
  logic [7:0] tx_shift;
  logic [2:0] tx_count;
  // Next byte loads on the last fall of the current one
  wire tx_at_boundary = (tx_count == sfpi_last_bit);
  assign tx_load = sck_fall & tx_at_boundary & (state == sfpi_active);
  always_ff @(posedge clock)
  begin
    if (hold_reset | cs_fall)
    begin
      tx_shift <= sfpi_byte_reset;
      tx_count <= sfpi_bit_count_reset;
    end
    else if (sck_fall && state == sfpi_active)
    begin
      tx_shift <= tx_at_boundary ? tx_byte : {tx_shift[6:0], 1'b0};
      tx_count <= tx_count + 3'h1;
    end
  end
  always_ff @(posedge clock)
  begin
    if (hold_reset)
    begin
      so_out <= 1'b0;
      so_oe_n <= 1'b1;
    end
    else
    begin
      so_out <= tx_shift[7];
      so_oe_n <= ~(selected && state == sfpi_active);
    end
  end

  // ****************************************
  // Write-protect gating
  // ****************************************
  function automatic logic sector_flag(input logic [7:0] flags, input logic [2:0] idx);
    sector_flag = flags[idx];
  endfunction
  wire is_array_op = (op_kind == sfpi_op_program) | (op_kind == sfpi_op_erase);
  wire hw_block = ~wp_n_s & sector_flag(prot_reg, op_sector);
  wire sw_block = soft_prot_armed & sector_flag(prot_reg, op_sector);
  wire prot_frozen = ~wp_n_s & (op_kind == sfpi_op_prot_write);
  wire always_ok = (op_kind == sfpi_op_prot_arm) | (op_kind == sfpi_op_lockdown);
  wire blocked = ~always_ok & ((is_array_op & (hw_block | sw_block)) | prot_frozen);
  wire op_take = op_valid & (state == sfpi_active) & ~hold_reset;
  always_ff @(posedge clock)
  begin
    if (hold_reset)
    begin
      op_accept <= 1'b0;
      op_reject <= 1'b0;
      busy_pending <= 1'b0;
    end
    else
    begin
      op_accept <= op_take & ~blocked;
      op_reject <= op_take & blocked;
      if (cs_fall)
        busy_pending <= 1'b0;
      else if (op_take & ~blocked & is_array_op)
        busy_pending <= 1'b1;
    end
  end
  // Flags survive the reset pin so it cannot lift protection
  always_ff @(posedge clock)
  begin
    if (srst)
      prot_reg <= sfpi_prot_reset;
    else if (op_take & ~blocked & (op_kind == sfpi_op_prot_write))
      prot_reg <= op_prot_data;
  end

  // ****************************************
  // Checks
  // ****************************************
  a_hiz_deselect: assert property (@(posedge clock) disable iff (srst)
    cs_n_d & cs_n_s |=> so_oe_n) else $error("output driven while deselected");
  a_wp_blocks_sector: assert property (@(posedge clock) disable iff (srst)
    op_take & is_array_op & ~wp_n_s & sector_flag(prot_reg, op_sector) |=> op_reject
    & ~op_accept) else $error("protected sector not rejected");
  a_soft_blocks: assert property (@(posedge clock) disable iff (srst)
    op_take & is_array_op & soft_prot_armed & sector_flag(prot_reg, op_sector) |=> op_reject)
    else $error("armed protection ignored");
  a_prot_frozen: assert property (@(posedge clock) disable iff (srst)
    ~wp_n_s & ~hold_reset |=> prot_reg == $past(prot_reg))
    else $error("protection changed under wp");
  a_arm_accepted: assert property (@(posedge clock) disable iff (srst)
    op_take & always_ok |=> op_accept) else $error("arm or lockdown refused");
  a_busy_holds: assert property (@(posedge clock) disable iff (srst)
    busy & ~busy_done & reset_n_s |=> busy) else $error("left busy early");
  a_reset_idle: assert property (@(posedge clock) disable iff (srst)
    ~reset_n_s |=> state == sfpi_reset && !rx_valid) else $error("reset not held");
  a_no_shift_desel: assert property (@(posedge clock) disable iff (srst)
    cs_n_s & cs_n_d |=> bit_count == $past(bit_count) || bit_count == 3'h0)
    else $error("shift while deselected");
  a_clear_on_select: assert property (@(posedge clock) disable iff (srst)
    cs_fall |=> bit_count == 3'h0 && rx_shift == 8'h00) else $error("counter not cleared");
  a_frame_start: assert property (@(posedge clock) disable iff (srst)
    frame_start |=> state == sfpi_active) else $error("select fall missed");
endmodule

//--- verification/sfpi_host_model.sv
// Host side model driving the serial flash pins
`timescale 1ns/1ps
module sfpi_host_model (
  input wire logic clock,
  input wire logic so_out,
  output logic cs_n,
  output logic sck,
  output logic si
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic select(input logic lvl);
    wait_clk(4);
    cs_n = lvl;
    wait_clk(4);
  endtask
  task automatic xfer(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - nbits; i--)
    begin
      si = tx[i];
      wait_clk(4);
      sck = 1'b1;
      rx[i] = so_out;
      wait_clk(4);
      sck = 1'b0;
    end
    wait_clk(4);
  endtask
endmodule

//--- verification/serial_flash_pin_interface_tb_top.sv
// Self-checking bench for the serial flash pin interface core
`timescale 1ns/1ps
module serial_flash_pin_interface_tb_top;
  import sfpi_pkg::*;
  logic clock;
  logic srst;
  logic cs_n;
  logic sck;
  logic si;
  logic wp_n;
  logic reset_n;
  logic so_out;
  logic so_oe_n;
  logic rx_valid;
  logic frame_start;
  logic frame_end;
  logic tx_load;
  logic op_valid;
  logic soft_prot_armed;
  logic busy_done;
  logic op_accept;
  logic op_reject;
  logic standby;
  logic busy;
  logic [7:0] rx_byte;
  logic [7:0] tx_byte;
  logic [7:0] op_prot_data;
  logic [7:0] prot_reg;
  logic [7:0] rxd;
  logic [2:0] op_kind;
  logic [2:0] op_sector;
  int failures = 0;
  int tests_run = 0;
  int n_rx = 0;
  int n_fs = 0;
  int n_fe = 0;
  int n_acc = 0;
  int n_rej = 0;
  int n_tl = 0;
  // Pull-up stands in for a released output
  wire so_pin = so_oe_n ? 1'b1 : so_out;
  sfpi_host_model host_u (.clock(clock), .so_out(so_pin), .cs_n(cs_n), .sck(sck), .si(si));
  sfpi_core dut_u (.clock(clock), .srst(srst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n),
    .reset_n(reset_n), .so_out(so_out), .so_oe_n(so_oe_n), .rx_byte(rx_byte),
    .rx_valid(rx_valid), .frame_start(frame_start), .frame_end(frame_end),
    .tx_byte(tx_byte), .tx_load(tx_load), .op_kind(op_kind), .op_sector(op_sector),
    .op_prot_data(op_prot_data), .op_valid(op_valid), .soft_prot_armed(soft_prot_armed),
    .busy_done(busy_done), .op_accept(op_accept), .op_reject(op_reject),
    .prot_reg(prot_reg), .standby(standby), .busy(busy));
  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock)
  begin
    n_rx += (rx_valid === 1'b1);
    n_fs += (frame_start === 1'b1);
    n_fe += (frame_end === 1'b1);
    n_acc += (op_accept === 1'b1);
    n_rej += (op_reject === 1'b1);
    n_tl += (tx_load === 1'b1);
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (failures == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic op(input sfpi_op_e k, input logic [2:0] s, input logic [7:0] d,
    input logic wp, input logic arm, input logic acc);
    int a0;
    int r0;
    a0 = n_acc;
    r0 = n_rej;
    wp_n = wp;
    soft_prot_armed = arm;
    op_kind = k;
    op_sector = s;
    op_prot_data = d;
    host_u.wait_clk(8);
    op_valid = 1'b1;
    host_u.wait_clk(1);
    op_valid = 1'b0;
    host_u.wait_clk(3);
    chk(8'(n_acc - a0), {7'h00, acc});
    chk(8'(n_rej - r0), {7'h00, ~acc});
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_rx();
    host_u.select(1'b0);
    chk(8'(n_fs), 8'h01);
    host_u.xfer(8'ha5, 8, rxd);
    chk(rx_byte, 8'ha5);
    host_u.xfer(8'h3c, 8, rxd);
    chk(rx_byte, 8'h3c);
    host_u.select(1'b1);
    chk(8'(n_fe), 8'h01);
    chk({7'h00, so_oe_n}, 8'h01);
    host_u.xfer(8'hff, 8, rxd);
    chk(8'(n_rx), 8'h02);
    chk(rxd, 8'hff);
    chk({7'h00, so_oe_n}, 8'h01);
  endtask
  task automatic t_partial();
    host_u.select(1'b0);
    host_u.xfer(8'hff, 3, rxd);
    host_u.select(1'b1);
    host_u.select(1'b0);
    host_u.xfer(8'h81, 8, rxd);
    chk(rx_byte, 8'h81);
    chk(8'(n_rx), 8'h03);
    host_u.select(1'b1);
  endtask
  task automatic t_tx();
    int t0;
    t0 = n_tl;
    tx_byte = 8'hc6;
    host_u.select(1'b0);
    host_u.xfer(8'h00, 8, rxd);
    host_u.xfer(8'h00, 8, rxd);
    chk(rxd, 8'hc6);
    chk(8'(n_tl - t0), 8'h02);
    chk({7'h00, so_oe_n}, 8'h00);
    host_u.select(1'b1);
    chk({7'h00, so_oe_n}, 8'h01);
  endtask
  task automatic t_prot();
    int i;
    host_u.select(1'b0);
    op(sfpi_op_prot_write, 3'h0, 8'h21, 1'b1, 1'b0, 1'b1);
    chk(prot_reg, 8'h21);
    op(sfpi_op_program, 3'h0, 8'h00, 1'b0, 1'b0, 1'b0);
    op(sfpi_op_prot_write, 3'h0, 8'hff, 1'b0, 1'b0, 1'b0);
    chk(prot_reg, 8'h21);
    op(sfpi_op_prot_arm, 3'h0, 8'h00, 1'b0, 1'b0, 1'b1);
    op(sfpi_op_lockdown, 3'h1, 8'h00, 1'b0, 1'b0, 1'b1);
    op(sfpi_op_erase, 3'h5, 8'h00, 1'b1, 1'b1, 1'b0);
    op(sfpi_op_program, 3'h2, 8'h00, 1'b1, 1'b0, 1'b1);
    host_u.select(1'b1);
    host_u.wait_clk(10);
    chk({6'h00, busy, standby}, 8'h02);
    busy_done = 1'b1;
    host_u.wait_clk(1);
    busy_done = 1'b0;
    for (i = 0; i < 20 && standby !== 1'b1; i++) host_u.wait_clk(1);
    chk({6'h00, busy, standby}, 8'h01);
  endtask
  task automatic t_reset();
    host_u.select(1'b0);
    host_u.xfer(8'hff, 4, rxd);
    reset_n = 1'b0;
    host_u.wait_clk(6);
    chk({7'h00, standby}, 8'h01);
    host_u.select(1'b1);
    reset_n = 1'b1;
    host_u.select(1'b0);
    host_u.xfer(8'h5a, 8, rxd);
    chk(rx_byte, 8'h5a);
    host_u.select(1'b1);
  endtask
  initial
  begin
    srst = 1'b1;
    wp_n = 1'b1;
    reset_n = 1'b1;
    tx_byte = 8'h00;
    op_kind = 3'h0;
    op_sector = 3'h0;
    op_prot_data = 8'h00;
    op_valid = 1'b0;
    soft_prot_armed = 1'b0;
    busy_done = 1'b0;
    host_u.wait_clk(16);
    srst = 1'b0;
    host_u.wait_clk(4);
    t_rx();
    t_partial();
    t_tx();
    t_prot();
    t_reset();
    tally_and_finish();
  end
endmodule
